// ---- inc/eeac_pkg.sv ----
/*
 * Constants for the on-chip data EEPROM access controller.
 * Assumes a CPU I/O bus carrying either 6-bit I/O addresses or
 * data-space addresses, where I/O register n sits at n plus 0x20.
 */
package eeac_pkg;
   // I/O and data-space addresses.
   localparam logic [5:0] IO_DONE    = 6'h1C;
   localparam logic [5:0] IO_CTRL    = 6'h1F;
   localparam logic [5:0] IO_DATA    = 6'h20;
   localparam logic [5:0] IO_ADDR_LO = 6'h21;
   localparam logic [5:0] IO_ADDR_HI = 6'h22;
   localparam logic [5:0] IO_BIT_MAX = 6'h1F;
   localparam logic [7:0] DS_IO_BASE = 8'h20;
   localparam logic [7:0] DS_IO_TOP  = 8'h5F;
   // Control and done register bit positions.
   localparam int CTRL_RE  = 0;
   localparam int CTRL_PE  = 1;
   localparam int CTRL_MPE = 2;
   localparam int CTRL_RIE = 3;
   localparam int CTRL_PM0 = 4;
   localparam int CTRL_PM1 = 5;
   localparam int DONE_BIT = 0;
   // Programming modes.
   localparam logic [1:0] PM_ATOMIC = 2'h0;
   localparam logic [1:0] PM_ERASE  = 2'h1;
   localparam logic [1:0] PM_WRITE  = 2'h2;
   localparam logic [1:0] PM_RSVD   = 2'h3;
   // Reset values and erased byte value.
   localparam logic [1:0]  MODE_RST = 2'h0;
   localparam logic [11:0] ADDR_RST = 12'h000;
   localparam logic [7:0]  DATA_RST = 8'h00;
   localparam logic [7:0]  ERASED   = 8'hFF;
   // Timing.
   localparam logic [2:0] MWE_CYCLES = 3'h4;
   localparam logic [2:0] WR_STALL   = 3'h2;
   localparam logic [2:0] RD_STALL   = 3'h4;
   localparam int T_ATOMIC_US   = 3400;
   localparam int T_SPLIT_US    = 1800;
   localparam int RC_WR_TICKS   = 26368;
   localparam int RC_SPLIT_TICKS = RC_WR_TICKS * T_SPLIT_US / T_ATOMIC_US;
   localparam int CNT_W = 15;
   typedef enum logic {ST_IDLE, ST_PROG} eeac_state_e;
endpackage : eeac_pkg

// ---- hw/eeac_ctrl.sv ----
/*
 * EEPROM access controller: address, data, control and done
 * registers in I/O space, a timed write interlock, RC-timed
 * programming of a 512-byte array, and CPU stall requests.
 * Assumes a CPU bus on this clock and an RC tick from elsewhere.
 */
// Functional notes
// - Data-space address is I/O address plus 0x20; I/O range 0x00-0x3F.
// - Bit set/clear at 0x00-0x1F touches only the addressed bit.
// - Some status flags clear by writing one.
// - Address high nibble reads zero; low twelve bits writable.
// - Data register supplies write byte and receives read byte.
// - Control bits 7 and 6 read zero.
// - Mode 00 erase+write, 01 erase, 10 write, 11 reserved.
// - Mode bits ignore writes while write strobe is set.
// - Reset clears mode bits unless programming is in progress.
// - Ready interrupt stays on while enabled, global enable set, idle.
// - Master enable clears after four cycles; strobe in window starts.
// - Strobe without master enable does nothing.
// - No EEPROM programming while Flash self-programming is active.
// - Hardware clears write strobe when programming time ends.
// - Write strobe halts the CPU two cycles.
// - Read strobe loads data at once and halts the CPU four cycles.
// - During a write, reads are refused and address cannot change.
// - Erase+write time is 26,368 RC oscillator cycles; erase or write alone takes 13,959.
// - Reset during a write lets the write complete.
`timescale 1ns/1ps
module eeac_ctrl #(
   parameter int ATOMIC_TICKS = eeac_pkg::RC_WR_TICKS,
   parameter int SPLIT_TICKS  = eeac_pkg::RC_SPLIT_TICKS,
   parameter int ADDR_BITS    = 9
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       por,
   input  wire logic [7:0] bus_addr,
   input  wire logic       bus_io,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   input  wire logic       bus_bset,
   input  wire logic       bus_bclr,
   input  wire logic [2:0] bus_bit,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       global_ie,
   input  wire logic       flash_selfprog_flag,
   input  wire logic       rc_tick,
   output logic      [7:0] bus_rdata,
   output logic            cpu_stall,
   output logic            cpu_irq
);
   import eeac_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic [7:0]          mem [2**ADDR_BITS];
   eeac_state_e         st_reg, st_next;
   logic [CNT_W-1:0]    cnt_reg, cnt_next;
   logic [1:0]          mode_reg, mode_next;
   logic                rie_reg, rie_next;
   logic                mwe_reg, mwe_next;
   logic [2:0]          mwc_reg, mwc_next;
   logic [11:0]         addr_reg, addr_next;
   logic [7:0]          data_reg, data_next;
   logic                done_reg, done_next;
   logic [2:0]          stc_reg, stc_next;
   logic                stall_next, irq_next;
   logic [7:0]          rdata_next;
   logic                rc_s1, rc_s2, rc_s3;
   logic                hit, we, pe_set, re_go, start, finish, tick;
   logic [5:0]          ioa;
   logic [7:0]          wv, wm;
   logic                mem_we;
   logic [7:0]          mem_wd;
   logic [ADDR_BITS-1:0] mem_a;

   // Maps an I/O or data-space address onto the I/O map.
   function automatic logic [6:0] io_decode(input logic [7:0] a,
                                            input logic       io);
      logic [7:0] d;
      d = a - DS_IO_BASE;
      if (io)
         return {a[7:6] == 2'b00, a[5:0]};
      return {a >= DS_IO_BASE && a <= DS_IO_TOP, d[5:0]};
   endfunction : io_decode

   function automatic logic [7:0] rd_val(input logic [5:0] a);
      case (a)
         IO_CTRL:    return {2'b00, mode_reg, rie_reg, mwe_reg,
                             st_reg == ST_PROG, 1'b0};
         IO_ADDR_LO: return addr_reg[7:0];
         IO_ADDR_HI: return {4'h0, addr_reg[11:8]};
         IO_DATA:    return data_reg;
         IO_DONE:    return {7'h00, done_reg};
         default:    return 8'h00;
      endcase
   endfunction : rd_val

   function automatic logic [CNT_W-1:0] ticks(input logic [1:0] m);
      if (m == PM_ATOMIC)
         return CNT_W'(ATOMIC_TICKS);
      return CNT_W'(SPLIT_TICKS);
   endfunction : ticks

   // Applies a masked write to an old value.
   function automatic logic [7:0] mw(input logic [7:0] o);
      return (o & ~wm) | (wv & wm);
   endfunction : mw

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      {hit, ioa} = io_decode(bus_addr, bus_io);
      wv = 8'h00;
      wm = 8'h00;
      we = 1'b0;
      if (bus_wr && hit) begin
         wv = bus_wdata;
         wm = 8'hFF;
         we = 1'b1;
      end else if ((bus_bset || bus_bclr) && bus_io && hit
                   && ioa <= IO_BIT_MAX) begin
         wm = 8'h01 << bus_bit;
         wv = bus_bset ? wm : 8'h00;
         we = 1'b1;
      end
      tick = rc_s2 && !rc_s3;
      st_next = st_reg;
      cnt_next = cnt_reg;
      mode_next = mode_reg;
      rie_next = rie_reg;
      mwe_next = mwe_reg;
      mwc_next = mwc_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      done_next = done_reg;
      stc_next = (stc_reg != 3'h0) ? stc_reg - 3'h1 : 3'h0;
      rdata_next = bus_rdata;
      mem_we = 1'b0;
      mem_wd = data_reg;
      mem_a = addr_reg[ADDR_BITS-1:0];
      pe_set = we && ioa == IO_CTRL && wm[CTRL_PE] && wv[CTRL_PE];
      re_go = we && ioa == IO_CTRL && wm[CTRL_RE] && wv[CTRL_RE]
              && st_reg == ST_IDLE;
      if (mwe_reg) begin
         if (mwc_reg == 3'h0)
            mwe_next = 1'b0;
         else
            mwc_next = mwc_reg - 3'h1;
      end
      if (we && ioa == IO_CTRL) begin
         rie_next = wm[CTRL_RIE] ? wv[CTRL_RIE] : rie_reg;
         if (st_reg == ST_IDLE)
            mode_next = 2'(mw({2'b00, mode_reg, 4'h0}) >> CTRL_PM0);
         if (wm[CTRL_MPE]) begin
            mwe_next = wv[CTRL_MPE];
            mwc_next = MWE_CYCLES - 3'h1;
         end
      end
      if (we && st_reg == ST_IDLE && ioa == IO_ADDR_LO)
         addr_next[7:0] = mw(addr_reg[7:0]);
      if (we && st_reg == ST_IDLE && ioa == IO_ADDR_HI)
         addr_next[11:8] = 4'(mw({4'h0, addr_reg[11:8]}));
      if (we && ioa == IO_DATA)
         data_next = mw(data_reg);
      if (we && ioa == IO_DONE && wm[DONE_BIT] && wv[DONE_BIT])
         done_next = 1'b0;
      start = pe_set && mwe_reg && st_reg == ST_IDLE
              && !flash_selfprog_flag
              && mode_next != PM_RSVD;
      if (start) begin
         st_next = ST_PROG;
         cnt_next = ticks(mode_next);
         mwe_next = 1'b0;
         stc_next = WR_STALL;
      end
      if (re_go) begin
         data_next = mem[mem_a];
         stc_next = RD_STALL;
      end
      finish = st_reg == ST_PROG && tick && cnt_reg == CNT_W'(1);
      if (st_reg == ST_PROG && tick) begin
         cnt_next = cnt_reg - CNT_W'(1);
         if (finish) begin
            st_next = ST_IDLE;
            done_next = 1'b1;
            mem_we = 1'b1;
            case (mode_reg)
               PM_ERASE: mem_wd = ERASED;
               PM_WRITE: mem_wd = mem[mem_a] & data_reg;
               default:  mem_wd = data_reg;
            endcase
         end
      end
      if (bus_rd && hit)
         rdata_next = rd_val(ioa);
      stall_next = stc_next != 3'h0;
      irq_next = rie_next && global_ie && st_next == ST_IDLE;
   end

   ////////////////////////////////////////////////////////////////////
   // Programming state, address and data survive an ordinary reset
   // while busy, so the byte in flight still lands where it should.
   always_ff @(posedge clock) begin
      if (por || (rst && st_reg == ST_IDLE)) begin
         st_reg <= ST_IDLE;
         cnt_reg <= '0;
         mode_reg <= MODE_RST;
         addr_reg <= ADDR_RST;
         data_reg <= DATA_RST;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         mode_reg <= mode_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
      end
   end

   always_ff @(posedge clock) begin
      if (por) begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_s3 <= 1'b0;
      end else begin
         rc_s1 <= rc_tick;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
      end
   end

   always_ff @(posedge clock) begin
      if (por || rst) begin
         rie_reg <= 1'b0;
         mwe_reg <= 1'b0;
         mwc_reg <= 3'h0;
         done_reg <= 1'b0;
         stc_reg <= 3'h0;
         cpu_stall <= 1'b0;
         cpu_irq <= 1'b0;
         bus_rdata <= 8'h00;
      end else begin
         rie_reg <= rie_next;
         mwe_reg <= mwe_next;
         mwc_reg <= mwc_next;
         done_reg <= done_next;
         stc_reg <= stc_next;
         cpu_stall <= stall_next;
         cpu_irq <= irq_next;
         bus_rdata <= rdata_next;
      end
   end

   always_ff @(posedge clock) begin
      if (mem_we)
         mem[mem_a] <= mem_wd;
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (por || rst);

   mwe_clear_a: assert property ($rose(mwe_reg)
      |-> ##[1:4] !mwe_reg)
      else $error("master enable not cleared in four cycles");
   addr_hi_a: assert property (bus_rd && hit && ioa == IO_ADDR_HI
      |=> bus_rdata[7:4] == 4'h0)
      else $error("address high nibble not zero");
   ctrl_rsvd_a: assert property (bus_rd && hit && ioa == IO_CTRL
      |=> bus_rdata[7:6] == 2'b00)
      else $error("control reserved bits not zero");
   mode_lock_a: assert property (st_reg == ST_PROG
      |=> $stable(mode_reg))
      else $error("mode changed while busy");
   irq_busy_a: assert property (st_reg == ST_PROG
      ##1 st_reg == ST_PROG |-> !cpu_irq)
      else $error("ready interrupt during write");
   no_mwe_a: assert property (pe_set && !mwe_reg && st_reg == ST_IDLE
      |=> st_reg == ST_IDLE)
      else $error("write started without master enable");
   flash_rsvd_a: assert property (st_reg == ST_IDLE
      && (flash_selfprog_flag || (mode_reg == PM_RSVD && !we))
      |=> st_reg == ST_IDLE)
      else $error("write started while blocked");
   wr_stall_a: assert property ($rose(st_reg == ST_PROG)
      |-> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write stall not two cycles");
   rd_stall_a: assert property (re_go
      |=> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read stall not four cycles");
   addr_hold_a: assert property (st_reg == ST_PROG
      |=> $stable(addr_reg))
      else $error("address changed while busy");
   done_a: assert property (finish
      |=> done_reg && st_reg == ST_IDLE)
      else $error("write end not flagged");
   keep_busy_a: assert property (disable iff (por)
      rst && st_reg == ST_PROG && !finish |=> st_reg == ST_PROG)
      else $error("reset aborted a write in progress");
   mode_reset_a: assert property (disable iff (por)
      rst && st_reg == ST_IDLE |=> mode_reg == MODE_RST)
      else $error("mode not cleared by reset when idle");

   busy_reset_c: cover property (disable iff (por) rst && st_reg == ST_PROG);
   start_c: cover property (start && mode_next == PM_ATOMIC);
   read_c: cover property (re_go);
   finish_c: cover property (finish && mode_reg == PM_WRITE);
endmodule : eeac_ctrl

// ---- verification/eeac_cpu_model.sv ----
/* CPU side of the I/O bus: byte writes, reads and single-bit sets.
   Assumes the controller takes strobes on the rising clock edge. */
`timescale 1ns/1ps
module eeac_cpu_model (
   input  wire logic       clock,
   output logic      [7:0] bus_addr,
   output logic            bus_io,
   output logic            bus_wr,
   output logic            bus_rd,
   output logic            bus_bset,
   output logic            bus_bclr,
   output logic      [2:0] bus_bit,
   output logic      [7:0] bus_wdata,
   input  wire logic [7:0] bus_rdata
);
   initial begin
      bus_addr = 8'h00;
      bus_io = 1'b1;
      {bus_wr, bus_rd, bus_bset, bus_bclr} = 4'h0;
      bus_bit = 3'h0;
      bus_wdata = 8'h00;
   end
   // One access held for one cycle; afterwards address and data are driven inverted.
   task automatic acc(input logic [3:0] op, input logic io,
                      input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d);
      @(negedge clock);
      bus_io = io;
      bus_addr = a;
      bus_bit = b;
      bus_wdata = d;
      {bus_wr, bus_rd, bus_bset, bus_bclr} = op;
      @(negedge clock);
      {bus_wr, bus_rd, bus_bset, bus_bclr} = 4'h0;
      bus_wdata = ~d;
      bus_addr = ~a;
   endtask : acc
   task automatic rd(input logic io, input logic [7:0] a,
                     output logic [7:0] d);
      acc(4'h4, io, a, 3'h0, 8'h00);
      @(negedge clock);
      d = bus_rdata;
   endtask : rd
endmodule : eeac_cpu_model

// ---- verification/eeac_ctrl_tb.sv ----
/* Self-checking bench for the EEPROM access controller.
   Assumes the CPU model drives the bus and the RC clock runs free. */
`timescale 1ns/1ps
module eeac_ctrl_tb;
   import eeac_pkg::*;
   localparam logic [7:0] A_CTRL = {2'h0, IO_CTRL};
   localparam logic [7:0] A_DATA = {2'h0, IO_DATA};
   localparam logic [7:0] A_LO   = {2'h0, IO_ADDR_LO};
   localparam logic [7:0] A_HI   = {2'h0, IO_ADDR_HI};
   localparam logic [7:0] A_DONE = {2'h0, IO_DONE};
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       por = 1'b1;
   logic       global_ie = 1'b0;
   logic       flash_selfprog_flag = 1'b0;
   logic       rc_tick = 1'b0;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, d;
   logic [2:0] bus_bit;
   logic       bus_io, bus_wr, bus_rd, bus_bset, bus_bclr;
   logic       cpu_stall, cpu_irq;
   int         error_cnt = 0;
   int         cmp_count = 0;
   logic [7:0] dat [4] = '{8'h5A, 8'h00, 8'h0F, 8'h33};
   logic [7:0] ex  [4] = '{8'h5A, 8'hFF, 8'h0F, 8'h0F};
   always #2 clock = ~clock;
   always #20 rc_tick = ~rc_tick;
   eeac_cpu_model cpu (.clock(clock), .bus_addr(bus_addr), .bus_io(bus_io),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bset(bus_bset),
      .bus_bclr(bus_bclr), .bus_bit(bus_bit), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata));
   eeac_ctrl #(.ATOMIC_TICKS(8), .SPLIT_TICKS(4)) dut (.clock(clock),
      .rst(rst), .por(por), .bus_addr(bus_addr), .bus_io(bus_io),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bset(bus_bset),
      .bus_bclr(bus_bclr), .bus_bit(bus_bit), .bus_wdata(bus_wdata),
      .global_ie(global_ie), .flash_selfprog_flag(flash_selfprog_flag),
      .rc_tick(rc_tick), .bus_rdata(bus_rdata), .cpu_stall(cpu_stall),
      .cpu_irq(cpu_irq));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, exp, input string what);
      logic [7:0] v;
      cpu.rd(1'b1, a, v);
      chk(what, v, exp);
   endtask : rdchk
   // Counts stall cycles starting in the cycle after the strobe edge.
   task automatic stalls(input logic [7:0] exp);
      logic [7:0] n;
      n = 8'h00;
      repeat (8) begin
         if (cpu_stall === 1'b1) n++;
         @(negedge clock);
      end
      chk("stall cycles", n, exp);
   endtask : stalls
   task automatic prog(input logic [1:0] md, input logic [7:0] v,
                       input logic [7:0] st);
      cpu.acc(4'h8, 1'b1, A_DATA, 3'h0, v);
      cpu.acc(4'h8, 1'b1, A_CTRL, 3'h0, {2'h0, md, 4'hC});
      cpu.acc(4'h2, 1'b1, A_CTRL, 3'h1, 8'h00);
      stalls(st);
   endtask : prog
   task automatic wait_idle;
      int i;
      i = 0;
      d = 8'h02;
      while (d[1] !== 1'b0 && i < 60) begin
         cpu.rd(1'b1, A_CTRL, d);
         i++;
      end
      chk("write strobe", {7'h0, d[1]}, 8'h00);
   endtask : wait_idle
   task automatic fetch(input logic [7:0] exp);
      cpu.acc(4'h2, 1'b1, A_CTRL, 3'h0, 8'h00);
      stalls(8'h04);
      rdchk(A_DATA, exp, "array byte");
   endtask : fetch
   task tally_and_finish;
      if (error_cnt == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish;
   end
   initial begin
      repeat (2) @(negedge clock);
      rst = 1'b0;
      por = 1'b0;
      rdchk(A_CTRL, 8'h00, "ctrl reset");
      cpu.acc(4'h8, 1'b1, A_HI, 3'h0, 8'hFF);
      rdchk(A_HI, 8'h0F, "addr high");
      cpu.acc(4'h8, 1'b0, A_LO + DS_IO_BASE, 3'h0, 8'h34);
      rdchk(A_LO, 8'h34, "addr low");
      cpu.acc(4'h8, 1'b1, A_HI, 3'h0, 8'h01);
      for (int i = 0; i < 4; i++) begin
         prog(i[1:0], dat[i], (i == 3) ? 8'h00 : 8'h02);
         wait_idle();
         fetch(ex[i]);
      end
      cpu.acc(4'h2, 1'b1, A_DONE, 3'h1, 8'h00);
      rdchk(A_DONE, 8'h01, "done kept");
      cpu.acc(4'h2, 1'b1, A_DONE, 3'h0, 8'h00);
      rdchk(A_DONE, 8'h00, "done cleared");
      prog(2'h1, 8'h00, 8'h02);
      cpu.acc(4'h8, 1'b1, A_LO, 3'h0, 8'h00);
      cpu.acc(4'h8, 1'b1, A_CTRL, 3'h0, 8'h28);
      rdchk(A_LO, 8'h34, "addr locked");
      rdchk(A_CTRL, 8'h1A, "mode locked");
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      cpu.rd(1'b1, A_CTRL, d);
      chk("ctrl after reset", d & 8'h32, 8'h12);
      wait_idle();
      fetch(8'hFF);
      cpu.acc(4'h8, 1'b1, A_CTRL, 3'h0, 8'h04);
      repeat (4) @(negedge clock);
      cpu.acc(4'h2, 1'b1, A_CTRL, 3'h1, 8'h00);
      stalls(8'h00);
      rdchk(A_CTRL, 8'h00, "late strobe");
      cpu.acc(4'h2, 1'b1, A_CTRL, 3'h1, 8'h00);
      stalls(8'h00);
      flash_selfprog_flag = 1'b1;
      prog(2'h0, 8'h00, 8'h00);
      rdchk(A_CTRL, 8'h08, "flash busy");
      flash_selfprog_flag = 1'b0;
      fetch(8'hFF);
      global_ie = 1'b1;
      repeat (2) @(negedge clock);
      chk("irq idle", {7'h0, cpu_irq}, 8'h01);
      prog(2'h2, 8'hFF, 8'h02);
      chk("irq busy", {7'h0, cpu_irq}, 8'h00);
      wait_idle();
      chk("irq done", {7'h0, cpu_irq}, 8'h01);
      global_ie = 1'b0;
      repeat (2) @(negedge clock);
      chk("irq masked", {7'h0, cpu_irq}, 8'h00);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      rdchk(A_CTRL, 8'h00, "ctrl idle reset");
      tally_and_finish;
   end
endmodule : eeac_ctrl_tb
